/* mgef_pkg.sv */
/*
  Constants, types and register map of the multicast group extension framer.
  Assumes one clock, APB register access and byte-wide frame streams.
*/
// Summary of operation
// - Group extension length byte is 3.
// - Group extension type field carries code 3.
// - Group extension critical flag is always one.
// - Continuation flag one means another unencrypted object follows; zero marks the last.
// - Group extension carries one group identifier byte naming the nonce state used.
// - Send missing-state extension when peer's follow-up group has no local nonce state.
// - Missing-state extension goes only in the unencrypted extension area.
// - Missing-state extension length byte is 2.
// - Missing-state extension type field carries code 4.
// - Missing-state extension critical flag is always zero.
// - Sequence number loads a random value at startup.
// - Sequence number advances once per new singlecast or follow-up, not on retransmit.
// - Group extension goes only in the unencrypted extension area.
// - Never put group extension and nonce state update in one frame.
// - Every multicast and singlecast follow-up frame carries a group extension.
package mgef_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HELD_GID = 8'h08;
  localparam logic [7:0] REG_HELD_VLD = 8'h0c;
  localparam logic [7:0] REG_RX_GID = 8'h10;
  // Command fields
  localparam int CMD_GID_LSB = 0;
  localparam int CMD_KIND_LSB = 8;
  localparam int CMD_MORE_BIT = 10;
  localparam int CMD_NSU_BIT = 11;
  localparam int CMD_RETX_BIT = 12;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MISS_PEND_BIT = 1;
  localparam int ST_PEER_LACKS_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_SEQ_LSB = 8;
  // Extension object encoding
  localparam logic [7:0] GRP_LEN = 8'h03;
  localparam logic [5:0] GRP_TYPE = 6'h03;
  localparam logic GRP_CRIT = 1'b1;
  localparam logic [7:0] MISS_LEN = 8'h02;
  localparam logic [5:0] MISS_TYPE = 6'h04;
  localparam logic MISS_CRIT = 1'b0;
  localparam int HDR_CONT_BIT = 7;
  localparam int HDR_CRIT_BIT = 6;
  // Reset values and FIFO depth
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_VLD = 4'h0;
  localparam int FIFO_DEPTH = 16;
  // Frame kinds
  typedef enum logic [1:0] {
    MGEF_SINGLE = 2'b00,
    MGEF_FOLLOW = 2'b01,
    MGEF_MULTI = 2'b10
  } mgef_kind_e;
  // One byte of the outgoing extension area
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } mgef_byte_s;
endpackage

/* mgef_framer.sv */
/*
  Extension area framer with its output FIFO and an APB register slave.
  Assumes synchronous inputs, a random source on entropy and a sink
  that may stall the byte stream.
*/
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Simple synchronous FIFO
module mgef_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Wrap-bit full test only works for a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  // Storage has no reset; only pointers matter
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
  // Pointer update
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Framer top
module mgef_framer #(
  parameter int SEQ_W = 8,
  parameter int DEPTH = mgef_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SEQ_W-1:0] entropy,
  output logic [SEQ_W-1:0] seq_num,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  input wire logic rx_followup
);
  // Status word has room for 24 sequence bits; the width is held to 1..16
  if (SEQ_W < 1 || SEQ_W > 16) begin : g_bad_seq
    $error("SEQ_W must be 1..16");
  end

  typedef enum logic [2:0] {
    MGEF_IDLE = 3'b000,
    MGEF_MLEN = 3'b001,
    MGEF_MHDR = 3'b010,
    MGEF_MGID = 3'b011,
    MGEF_OLEN = 3'b100,
    MGEF_OHDR = 3'b101
  } mgef_state_e;

  // Header byte builder, shared by both objects
  function automatic logic [7:0] mgef_hdr(input logic cont, input logic crit,
                                          input logic [5:0] typ);
    mgef_hdr = {cont, crit, typ};
  endfunction

  // Lookup in the held nonce state table
  function automatic logic mgef_held(input logic [31:0] gids, input logic [3:0] vld,
                                     input logic [7:0] gid);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (vld[i] && gids[8*i +: 8] == gid) hit = 1'b1;
    end
    mgef_held = hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [31:0] held_gid_q;
  logic [3:0] held_vld_q;
  logic [7:0] rx_gid_q, gid_q;
  logic more_q, grp_q, miss_q;
  logic miss_pend_q, peer_lacks_q, refused_q, started_q;
  logic [SEQ_W-1:0] seq_q;
  mgef_state_e st_q, st_d;

  wire wr_en = psel && penable && pwrite;
  wire hit_cmd = paddr == mgef_pkg::REG_CMD;
  wire hit_st = paddr == mgef_pkg::REG_STATUS;
  wire hit_hg = paddr == mgef_pkg::REG_HELD_GID;
  wire hit_hv = paddr == mgef_pkg::REG_HELD_VLD;
  wire hit_rx = paddr == mgef_pkg::REG_RX_GID;
  wire mapped = hit_cmd || hit_st || hit_hg || hit_hv || hit_rx;
  wire busy = st_q != MGEF_IDLE;
  wire [31:0] status_w = {{(24 - SEQ_W){1'b0}}, seq_q, 4'h0, refused_q,
                          peer_lacks_q, miss_pend_q, busy};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
                  hit_st ? status_w :
                  hit_hg ? held_gid_q :
                  hit_hv ? {28'h0000000, held_vld_q} :
                  hit_rx ? {24'h000000, rx_gid_q} : 32'h0000_0000;

  // Command decode
  wire cmd_wr = wr_en && hit_cmd;
  wire [1:0] cmd_kind = pwdata[mgef_pkg::CMD_KIND_LSB +: 2];
  wire cmd_grp = cmd_kind == mgef_pkg::MGEF_FOLLOW || cmd_kind == mgef_pkg::MGEF_MULTI;
  wire cmd_nsu = pwdata[mgef_pkg::CMD_NSU_BIT];
  wire cmd_refuse = cmd_wr && (busy || (cmd_grp && cmd_nsu));
  wire cmd_go = cmd_wr && !cmd_refuse;
  wire cmd_seq = cmd_go && !pwdata[mgef_pkg::CMD_RETX_BIT] &&
                 cmd_kind != mgef_pkg::MGEF_MULTI;
  wire cmd_miss = miss_pend_q;

  // Held table
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_gid_q <= {4{mgef_pkg::RST_BYTE}};
      held_vld_q <= mgef_pkg::RST_VLD;
    end else begin
      if (wr_en && hit_hg) held_gid_q <= pwdata;
      if (wr_en && hit_hv) held_vld_q <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence number
  // Loaded from entropy on the first edge after reset, never a constant
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      started_q <= 1'b0;
      seq_q <= '0;
    end else if (!started_q) begin
      started_q <= 1'b1;
      seq_q <= entropy;
    end else if (cmd_seq) begin
      seq_q <= seq_q + 1'b1;
    end
  end
  assign seq_num = seq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame command latch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gid_q <= mgef_pkg::RST_BYTE;
      more_q <= 1'b0;
      grp_q <= 1'b0;
      miss_q <= 1'b0;
    end else if (cmd_go) begin
      gid_q <= pwdata[mgef_pkg::CMD_GID_LSB +: 8];
      more_q <= pwdata[mgef_pkg::CMD_MORE_BIT];
      grp_q <= cmd_grp;
      miss_q <= cmd_miss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Extension area emitter
  mgef_pkg::mgef_byte_s out_b;
  logic push_ok, push;
  wire nothing = !cmd_grp && !cmd_miss;
  // Group object continues when a missing-state object or caller's object follows
  wire grp_cont = miss_q || more_q;
  always_comb begin
    st_d = st_q;
    out_b = '{last: 1'b0, data: 8'h00};
    push = 1'b0;
    unique case (st_q)
      MGEF_IDLE: begin
        if (cmd_go && !nothing) st_d = cmd_grp ? MGEF_MLEN : MGEF_OLEN;
      end
      MGEF_MLEN: begin
        out_b.data = mgef_pkg::GRP_LEN;
        push = 1'b1;
        if (push_ok) st_d = MGEF_MHDR;
      end
      MGEF_MHDR: begin
        out_b.data = mgef_hdr(grp_cont, mgef_pkg::GRP_CRIT, mgef_pkg::GRP_TYPE);
        push = 1'b1;
        if (push_ok) st_d = MGEF_MGID;
      end
      MGEF_MGID: begin
        out_b.data = gid_q;
        out_b.last = !miss_q;
        push = 1'b1;
        if (push_ok) st_d = miss_q ? MGEF_OLEN : MGEF_IDLE;
      end
      MGEF_OLEN: begin
        out_b.data = mgef_pkg::MISS_LEN;
        push = 1'b1;
        if (push_ok) st_d = MGEF_OHDR;
      end
      MGEF_OHDR: begin
        out_b.data = mgef_hdr(more_q, mgef_pkg::MISS_CRIT, mgef_pkg::MISS_TYPE);
        out_b.last = 1'b1;
        push = 1'b1;
        if (push_ok) st_d = MGEF_IDLE;
      end
      default: st_d = MGEF_IDLE;
    endcase
  end

  // Emitter state; stalls while the FIFO is full
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) st_q <= MGEF_IDLE;
    else st_q <= st_d;
  end

  // Only the unencrypted extension area passes through this stream
  mgef_pkg::mgef_byte_s fifo_out;
  mgef_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(out_b),
    .in_valid(push),
    .in_ready(push_ok),
    .out_data(fifo_out),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );
  assign tx_data = fifo_out.data;
  assign tx_last = fifo_out.last;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive parser of the peer's unencrypted extension area
  logic [7:0] rx_idx_q, rx_len_q;
  logic [5:0] rx_typ_q;
  logic rx_cont_q, rx_done_q;
  wire rx_take = rx_valid && !rx_done_q;
  // A two-byte object ends on its header byte, so index 1 may end it
  wire rx_end = rx_idx_q != 8'h00 && rx_idx_q + 8'h01 >= rx_len_q;
  // While the header is taken its own flag counts, not the stale register
  wire rx_cont = rx_idx_q == 8'h01 ? rx_data[mgef_pkg::HDR_CONT_BIT] : rx_cont_q;
  wire rx_gid_byte = rx_take && rx_idx_q == 8'h02 && rx_typ_q == mgef_pkg::GRP_TYPE;
  wire rx_miss = rx_gid_byte && rx_followup &&
                 !mgef_held(held_gid_q, held_vld_q, rx_data);
  wire rx_lack = rx_take && rx_idx_q == 8'h01 &&
                 rx_data[5:0] == mgef_pkg::MISS_TYPE;
  // Byte walker; a zero continuation flag ends the area
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_idx_q <= 8'h00;
      rx_len_q <= 8'h00;
      rx_typ_q <= 6'h00;
      rx_cont_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else if (rx_sof) begin
      rx_idx_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else if (rx_take) begin
      if (rx_idx_q == 8'h00) rx_len_q <= rx_data;
      if (rx_idx_q == 8'h01) begin
        rx_typ_q <= rx_data[5:0];
        rx_cont_q <= rx_data[mgef_pkg::HDR_CONT_BIT];
      end
      if (rx_end) begin
        rx_idx_q <= 8'h00;
        rx_done_q <= !rx_cont;
      end else begin
        rx_idx_q <= rx_idx_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags: hardware set wins over software clear
  wire st_wr = wr_en && hit_st;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      miss_pend_q <= 1'b0;
      peer_lacks_q <= 1'b0;
      refused_q <= 1'b0;
      rx_gid_q <= mgef_pkg::RST_BYTE;
    end else begin
      if (rx_gid_byte) rx_gid_q <= rx_data;
      // Pending request is consumed by the next accepted frame
      if (rx_miss) miss_pend_q <= 1'b1;
      else if (cmd_go || (st_wr && pwdata[mgef_pkg::ST_MISS_PEND_BIT])) miss_pend_q <= 1'b0;
      if (rx_lack) peer_lacks_q <= 1'b1;
      else if (st_wr && pwdata[mgef_pkg::ST_PEER_LACKS_BIT]) peer_lacks_q <= 1'b0;
      if (cmd_refuse) refused_q <= 1'b1;
      else if (st_wr && pwdata[mgef_pkg::ST_REFUSED_BIT]) refused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_grp_len;
    @(posedge ref_clk) disable iff (rst)
      (st_q == MGEF_MLEN && push_ok) |-> out_b.data == 8'h03;
  endproperty
  a_grp_len: assert property (p_grp_len) else $error("group length not 3");

  property p_grp_hdr;
    @(posedge ref_clk) disable iff (rst)
      (st_q == MGEF_MHDR) |-> out_b.data[6:0] == 7'h43 && out_b.data[7] == (miss_q || more_q);
  endproperty
  a_grp_hdr: assert property (p_grp_hdr) else $error("group header wrong");

  property p_grp_crit;
    @(posedge ref_clk) disable iff (rst)
      (st_q == MGEF_MHDR) |-> out_b.data[6];
  endproperty
  a_grp_crit: assert property (p_grp_crit) else $error("group critical flag low");

  property p_miss_obj;
    @(posedge ref_clk) disable iff (rst)
      (st_q == MGEF_OLEN && push_ok) |=> out_b.data[6:0] == 7'h04 && out_b.last;
  endproperty
  a_miss_obj: assert property (p_miss_obj) else $error("missing-state header wrong");

  property p_miss_len;
    @(posedge ref_clk) disable iff (rst)
      (st_q == MGEF_OLEN) |-> out_b.data == 8'h02 && !out_b.last;
  endproperty
  a_miss_len: assert property (p_miss_len) else $error("missing-state length not 2");

  property p_gid;
    @(posedge ref_clk) disable iff (rst)
      cmd_go |=> grp_q == $past(cmd_grp) && gid_q == $past(pwdata[7:0]);
  endproperty
  a_gid: assert property (p_gid) else $error("group identifier not latched");

  property p_seq;
    @(posedge ref_clk) disable iff (rst)
      started_q && !cmd_seq |=> seq_q == $past(seq_q);
  endproperty
  a_seq: assert property (p_seq) else $error("sequence moved without new frame");

  property p_seq_inc;
    @(posedge ref_clk) disable iff (rst)
      started_q && cmd_seq |=> seq_q == $past(seq_q) + 1'b1;
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("sequence did not advance");

  property p_seed;
    @(posedge ref_clk) disable iff (rst)
      !started_q |=> started_q && seq_q == $past(entropy);
  endproperty
  a_seed: assert property (p_seed) else $error("sequence not seeded");

  property p_no_mix;
    @(posedge ref_clk) disable iff (rst)
      (cmd_wr && cmd_grp && cmd_nsu) |=> refused_q && ($past(busy) || !busy);
  endproperty
  a_no_mix: assert property (p_no_mix) else $error("group frame with nonce update");

  property p_miss;
    @(posedge ref_clk) disable iff (rst)
      rx_miss |=> miss_pend_q;
  endproperty
  a_miss: assert property (p_miss) else $error("missing state not flagged");
endmodule

/* mgef_peer.sv */
/*
  Peer receiver model for the framer's extension stream, and the source of
  the peer's own extension area. Assumes one clock and a caller that uses
  set_stall and send_area from the bench's main sequence.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mgef_peer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_data,
  output logic rx_followup
);
  mgef_pkg::mgef_byte_s got[$];
  logic stall = 1'b0;
  int pos = 0;
  int len = 0;
  logic cont = 1'b0;
  int proto_err = 0;

  // Quiet receive lines until the first frame
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'h00;
    rx_followup = 1'b0;
  end

  // Stall is the only way this sink holds back
  assign tx_ready = !stall;

  // Collect taken bytes, walk objects by their length byte
  always @(posedge ref_clk) begin
    if (!rst && tx_valid && tx_ready) begin
      got.push_back('{last: tx_last, data: tx_data});
      if (pos == 0) len = int'(tx_data);
      if (pos == 1) cont = tx_data[7];
      pos++;
      if (pos >= len && pos >= 2) begin
        // A final object must not be followed by more of ours
        if (!cont && !tx_last) proto_err++;
        pos = 0;
      end
      if (tx_last) pos = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sink stall control, applied just after an edge
  task automatic set_stall(input logic v);
    @(posedge ref_clk);
    stall <= v;
  endtask

  // One peer area: start pulse, bytes, then a scrambled idle data line
  task automatic send_area(input logic [7:0] b[$], input logic fu);
    @(posedge ref_clk);
    rx_sof <= 1'b1;
    rx_followup <= fu;
    foreach (b[i]) begin
      @(posedge ref_clk);
      rx_sof <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b[i];
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b[b.size()-1];
  endtask
endmodule

/* tb_multicast_group_ext_framer.sv */
/*
  Self-checking bench for the framer: APB master tasks, peer model and
  byte-stream comparisons. Assumes the framer answers APB with pready.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_multicast_group_ext_framer;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, entropy, seq_num, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd;
  logic tx_last, tx_valid, tx_ready, rx_valid, rx_sof, rx_followup, err;
  int fails = 0;
  int n_compared = 0;
  logic [8:0] q[$];

  mgef_framer dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .entropy(entropy), .seq_num(seq_num), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_data(rx_data), .rx_followup(rx_followup));
  mgef_peer peer_u (.ref_clk(ref_clk), .rst(rst), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .rx_followup(rx_followup));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll busy with a bound; stuck busy fails the idle compare that ends this task
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[mgef_pkg::ST_BUSY_BIT] !== 1'b0 && n < 200);
    check("idle", 32'h0, 32'(rd[mgef_pkg::ST_BUSY_BIT]));
  endtask

  // Wait for the expected bytes, then make sure nothing else follows
  task automatic expect_area(input logic [8:0] e[$], input string what);
    int n;
    n = 0;
    while (peer_u.got.size() < e.size() && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (8) @(posedge ref_clk);
    check({what, " count"}, 32'(e.size()), 32'(peer_u.got.size()));
    foreach (e[i]) if (i < peer_u.got.size()) check(what, 32'(e[i]), 32'(peer_u.got[i]));
    peer_u.got.delete();
    check({what, " idle"}, 32'h0, 32'(tx_valid));
  endtask

  function automatic logic [31:0] cmd(input logic [1:0] k, input logic [7:0] g,
      input int more, input int nsu, input int retx);
    logic [31:0] w;
    w = {19'h0, 1'(retx), 1'(nsu), 1'(more), k, g};
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    entropy = 8'hc5;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("seq seed", 32'hc5, 32'(seq_num));
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("status", 32'h0000c500, rd);
    apb(1'b0, mgef_pkg::REG_RX_GID, 32'h0);
    check("rx gid", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", 32'h1, 32'(err));
    $display("test done: reset");
    // Group objects: header is {cont, 1, 000011}
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_FOLLOW, 8'h5a, 0, 0, 0));
    expect_area('{9'h003, 9'h043, 9'h15a}, "follow");
    check("seq follow", 32'hc6, 32'(seq_num));
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_MULTI, 8'h81, 1, 0, 0));
    expect_area('{9'h003, 9'h0c3, 9'h181}, "multi");
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_SINGLE, 8'h00, 0, 0, 0));
    expect_area(q, "single");
    check("seq single", 32'hc7, 32'(seq_num));
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_FOLLOW, 8'h5a, 0, 0, 1));
    expect_area('{9'h003, 9'h043, 9'h15a}, "retx");
    check("seq retx", 32'hc7, 32'(seq_num));
    $display("test done: group objects");
    // Group object with nonce update is refused
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_FOLLOW, 8'h22, 0, 1, 0));
    expect_area(q, "refused");
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("refused flag", 32'h1, 32'(rd[mgef_pkg::ST_REFUSED_BIT]));
    apb(1'b1, mgef_pkg::REG_STATUS, 32'h8);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("refused clear", 32'h0, 32'(rd[3:0]));
    $display("test done: refusal");
    // Missing state only for an unheld group on a follow-up
    peer_u.send_area('{8'h03, 8'h43, 8'h55}, 1'b0);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("no pend single", 32'h0, 32'(rd[mgef_pkg::ST_MISS_PEND_BIT]));
    peer_u.send_area('{8'h03, 8'h43, 8'h09}, 1'b1);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("pend", 32'h1, 32'(rd[mgef_pkg::ST_MISS_PEND_BIT]));
    apb(1'b0, mgef_pkg::REG_RX_GID, 32'h0);
    check("rx gid", 32'h09, rd);
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_SINGLE, 8'h00, 0, 0, 0));
    expect_area('{9'h002, 9'h104}, "missing");
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("pend clear", 32'h0, 32'(rd[mgef_pkg::ST_MISS_PEND_BIT]));
    apb(1'b1, mgef_pkg::REG_HELD_GID, 32'h00000009);
    apb(1'b1, mgef_pkg::REG_HELD_VLD, 32'h1);
    peer_u.send_area('{8'h03, 8'h43, 8'h09}, 1'b1);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("held no pend", 32'h0, 32'(rd[mgef_pkg::ST_MISS_PEND_BIT]));
    peer_u.send_area('{8'h03, 8'h43, 8'h33}, 1'b1);
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_FOLLOW, 8'h44, 1, 0, 0));
    expect_area('{9'h003, 9'h0c3, 9'h044, 9'h002, 9'h184}, "both");
    $display("test done: missing state");
    // Peer reports it lacks state, then a group object follows in one area
    peer_u.send_area('{8'h02, 8'h84, 8'h03, 8'h43, 8'h66}, 1'b0);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("peer lacks", 32'h1, 32'(rd[mgef_pkg::ST_PEER_LACKS_BIT]));
    apb(1'b0, mgef_pkg::REG_RX_GID, 32'h0);
    check("rx gid chained", 32'h66, rd);
    apb(1'b1, mgef_pkg::REG_STATUS, 32'h4);
    apb(1'b0, mgef_pkg::REG_HELD_GID, 32'h0);
    check("held gid", 32'h9, rd);
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("lacks clear", 32'h0, 32'(rd[3:0]));
    $display("test done: peer objects");
    // Fill the FIFO with the sink stalled, then drain it
    peer_u.set_stall(1'b1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_MULTI, 8'h10 + 8'(i), 0, 0, 0));
      if (i < 5) wait_idle();
      q.push_back(9'h003);
      q.push_back(9'h043);
      q.push_back({1'b1, 8'h10 + 8'(i)});
    end
    repeat (20) @(posedge ref_clk);
    apb(1'b1, mgef_pkg::REG_CMD, cmd(mgef_pkg::MGEF_MULTI, 8'h77, 0, 0, 0));
    apb(1'b0, mgef_pkg::REG_STATUS, 32'h0);
    check("full busy", 32'h9, 32'(rd[3:0]));
    peer_u.set_stall(1'b0);
    expect_area(q, "fifo");
    q.delete();
    check("peer framing", 32'h0, 32'(peer_u.proto_err));
    $display("test done: fifo");
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    summarize();
  end
endmodule
